// ==== rtl/cmd_decode_pkg.sv ====
package cmd_decode_pkg;

  // Decoded command codes presented on the command output.
  typedef enum logic [4:0] {
    CMD_NONE,
    CMD_DESELECT,
    CMD_NOOP,
    CMD_MODE_SET,
    CMD_REFRESH,
    CMD_SELF_REF_ENTER,
    CMD_SELF_REF_EXIT,
    CMD_PRECHARGE,
    CMD_PRECHARGE_ALL,
    CMD_ACTIVATE,
    CMD_WRITE,
    CMD_READ,
    CMD_ZQ_LONG,
    CMD_ZQ_SHORT,
    CMD_POWER_DOWN_ENTER,
    CMD_POWER_DOWN_EXIT,
    CMD_ILLEGAL
  } cmd_t;

  // Power state of the device as seen by the decoder.
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_POWER_DOWN,
    PWR_SELF_REFRESH
  } pwr_t;

  // Address bit positions with a special meaning on column, precharge and ZQ commands.
  localparam int AUTO_PRE_BIT  = 10;
  localparam int BURST_SEL_BIT = 12;

  // Burst lengths in data beats.
  localparam logic [3:0] BURST_FULL = 4'h8;
  localparam logic [3:0] BURST_CHOP = 4'h4;

  // A burst of N beats occupies N/2 clocks on a double data rate bus.
  localparam int BEATS_PER_CLK = 2;

  // Mode register index that carries the burst length field.
  localparam logic [2:0] MR_BURST_IDX = 3'h0;

  // Burst length field encodings in the low opcode bits of that register.
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // Reset value of the burst length field.
  localparam logic [1:0] BL_RESET = BL_FIXED8;

endpackage : cmd_decode_pkg

// ==== rtl/cmd_decoder.sv ====
`timescale 1ns/10ps

module cmd_decoder
  import cmd_decode_pkg::*;
#(
  parameter int BANK_W = 3,
  parameter int ROW_W  = 15,
  parameter int COL_W  = 10,
  parameter int ADDR_W = 15
) (
  // Clock and asynchronous reset.
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Command pins from the controller; cs_n, ras_n, cas_n and we_n are active low strobes.
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BANK_W-1:0] bank_addr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              odt,
  // Decoded command, one cycle pulse with its fields.
  output logic                   cmd_valid,
  output cmd_t                   cmd,
  output logic [BANK_W-1:0]      cmd_bank,
  output logic [ROW_W-1:0]       cmd_row,
  output logic [COL_W-1:0]       cmd_col,
  output logic                   cmd_auto_pre,
  output logic [3:0]             cmd_burst_len,
  output logic [2:0]             mr_sel,
  output logic [ADDR_W-1:0]      mr_opcode,
  // Device state.
  output logic                   burst_busy,
  output pwr_t                   pwr_state,
  output logic                   odt_enable,
  output logic                   self_ref_wake
);

  // Reset release through two flip-flops.
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Input synchronisers: first stage read only by the second stage.
  localparam int PIN_W = 6 + BANK_W + ADDR_W;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      pin_s1_q <= {{(PIN_W-6){1'b0}}, 6'h1e};
      pin_s2_q <= {{(PIN_W-6){1'b0}}, 6'h1e};
    end else begin
      pin_s1_q <= {addr, bank_addr, odt, cke, cs_n, ras_n, cas_n, we_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Named views of the synchronised pins.
  logic              s_we_n;
  logic              s_cas_n;
  logic              s_ras_n;
  logic              s_cs_n;
  logic              s_cke;
  logic              s_odt;
  logic [BANK_W-1:0] s_bank;
  logic [ADDR_W-1:0] s_addr;
  assign {s_addr, s_bank, s_odt, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n} = pin_s2_q;

  // Self refresh wake: CKE rising toggles a flag without the clock.
  logic wake_q;
  logic wake_s1_q;
  logic wake_s2_q;
  logic in_sr;
  always_ff @(posedge cke or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= ~wake_q;
    end
  end
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_q;
      wake_s2_q <= wake_s1_q;
    end
  end

  // Decoder state.
  logic       cke_prev_q, cke_prev_d;
  logic       wake_seen_q, wake_seen_d;
  pwr_t       pwr_q, pwr_d;
  logic [1:0] bl_mode_q, bl_mode_d;
  logic [2:0] burst_cnt_q, burst_cnt_d;
  logic       vld_q, vld_d;
  cmd_t       cmd_q, cmd_d;
  logic [BANK_W-1:0] bank_q, bank_d;
  logic [ROW_W-1:0]  row_q, row_d;
  logic [COL_W-1:0]  col_q, col_d;
  logic       ap_q, ap_d;
  logic [3:0] bl_q, bl_d;
  logic [2:0] mrs_q, mrs_d;
  logic [ADDR_W-1:0] op_q, op_d;

  assign in_sr = (pwr_q == PWR_SELF_REFRESH);

  // Next-state decode of one command per edge.
  always_comb begin
    logic [2:0] pat;
    logic [3:0] len;
    pat         = {s_ras_n, s_cas_n, s_we_n};
    len         = BURST_FULL;
    cke_prev_d  = s_cke;
    wake_seen_d = wake_s2_q;
    pwr_d       = pwr_q;
    bl_mode_d   = bl_mode_q;
    burst_cnt_d = (burst_cnt_q != 3'h0) ? burst_cnt_q - 3'h1 : 3'h0;
    vld_d       = 1'b0;
    cmd_d       = CMD_NONE;
    bank_d      = bank_q;
    row_d       = row_q;
    col_d       = col_q;
    ap_d        = ap_q;
    bl_d        = bl_q;
    mrs_d       = mrs_q;
    op_d        = op_q;
    // Burst length choice for reads and writes.
    if (bl_mode_q == BL_OTF) begin
      len = s_addr[BURST_SEL_BIT] ? BURST_FULL : BURST_CHOP;
    end else if (bl_mode_q == BL_FIXED4) begin
      len = BURST_CHOP;
    end
    if (in_sr) begin
      // Wake toggle from the CKE edge ends self refresh.
      if (wake_s2_q != wake_seen_q) begin
        pwr_d = PWR_ACTIVE;
        vld_d = 1'b1;
        cmd_d = CMD_SELF_REF_EXIT;
      end
    end else if (pwr_q == PWR_POWER_DOWN) begin
      // Power-down holds until CKE is seen high; no refresh inside.
      if (!cke_prev_q && s_cke) begin
        pwr_d = PWR_ACTIVE;
        vld_d = 1'b1;
        cmd_d = CMD_POWER_DOWN_EXIT;
      end
    end else if (cke_prev_q && !s_cke) begin
      // CKE falling: self refresh entry or power-down entry.
      vld_d = 1'b1;
      if (!s_cs_n && pat == 3'h1) begin
        pwr_d = PWR_SELF_REFRESH;
        cmd_d = CMD_SELF_REF_ENTER;
      end else begin
        pwr_d = PWR_POWER_DOWN;
        cmd_d = CMD_POWER_DOWN_ENTER;
      end
    end else if (cke_prev_q && s_cke) begin
      vld_d = 1'b1;
      if (s_cs_n) begin
        cmd_d = CMD_DESELECT;
      end else begin
        unique case (pat)
          3'h0: begin
            cmd_d = CMD_MODE_SET;
            mrs_d = 3'(s_bank);
            op_d  = s_addr;
            if (3'(s_bank) == MR_BURST_IDX) begin
              bl_mode_d = s_addr[1:0];
            end
          end
          3'h1: cmd_d = CMD_REFRESH;
          3'h2: begin
            cmd_d  = s_addr[AUTO_PRE_BIT] ? CMD_PRECHARGE_ALL : CMD_PRECHARGE;
            bank_d = s_bank;
          end
          3'h3: begin
            cmd_d  = CMD_ACTIVATE;
            bank_d = s_bank;
            row_d  = ROW_W'(s_addr);
          end
          3'h4, 3'h5: begin
            cmd_d  = (pat == 3'h4) ? CMD_WRITE : CMD_READ;
            bank_d = s_bank;
            col_d  = COL_W'(s_addr);
            ap_d   = s_addr[AUTO_PRE_BIT];
            bl_d   = len;
            // A new burst may only lengthen the count, never cut a running one.
            if (3'(len / BEATS_PER_CLK) > burst_cnt_d) begin
              burst_cnt_d = 3'(len / BEATS_PER_CLK);
            end
          end
          3'h6: cmd_d = s_addr[AUTO_PRE_BIT] ? CMD_ZQ_LONG : CMD_ZQ_SHORT;
          3'h7: cmd_d = CMD_NOOP;
        endcase
      end
    end else begin
      cmd_d = CMD_ILLEGAL;
      vld_d = 1'b1;
    end
  end

  // Register the decoder state.
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      // Matches the idle CKE level of the pin stage, so no false edge after reset.
      cke_prev_q  <= 1'b1;
      wake_seen_q <= 1'b0;
      pwr_q       <= PWR_ACTIVE;
      bl_mode_q   <= BL_RESET;
      burst_cnt_q <= 3'h0;
      vld_q       <= 1'b0;
      cmd_q       <= CMD_NONE;
      bank_q      <= '0;
      row_q       <= '0;
      col_q       <= '0;
      ap_q        <= 1'b0;
      bl_q        <= BURST_FULL;
      mrs_q       <= 3'h0;
      op_q        <= '0;
    end else begin
      cke_prev_q  <= cke_prev_d;
      wake_seen_q <= wake_seen_d;
      pwr_q       <= pwr_d;
      bl_mode_q   <= bl_mode_d;
      burst_cnt_q <= burst_cnt_d;
      vld_q       <= vld_d;
      cmd_q       <= cmd_d;
      bank_q      <= bank_d;
      row_q       <= row_d;
      col_q       <= col_d;
      ap_q        <= ap_d;
      bl_q        <= bl_d;
      mrs_q       <= mrs_d;
      op_q        <= op_d;
    end
  end

  // Outputs from flip-flops, burst_busy, odt_enable and self_ref_wake through gates; termination is off in self refresh.
  assign cmd_valid     = vld_q;
  assign cmd           = cmd_q;
  assign cmd_bank      = bank_q;
  assign cmd_row       = row_q;
  assign cmd_col       = col_q;
  assign cmd_auto_pre  = ap_q;
  assign cmd_burst_len = bl_q;
  assign mr_sel        = mrs_q;
  assign mr_opcode     = op_q;
  assign burst_busy    = (burst_cnt_q != 3'h0);
  assign pwr_state     = pwr_q;
  assign odt_enable    = s_odt && !in_sr;
  assign self_ref_wake = wake_s2_q ^ wake_seen_q;

endmodule // cmd_decoder

// ==== dv/cmd_decoder_asserts.sv ====
`timescale 1ns/10ps
module cmd_decoder_asserts
  import cmd_decode_pkg::*;
#(parameter int BANK_W = 3, parameter int ADDR_W = 15) (
  // Clock, reset and pins.
  input wire logic clk, rst_n, cke, cs_n, ras_n, cas_n, we_n, odt,
  input wire logic [BANK_W-1:0] bank_addr,
  input wire logic [ADDR_W-1:0] addr,
  // Decoded outputs.
  input wire logic cmd_valid, cmd_auto_pre, burst_busy, odt_enable,
  input wire cmd_t cmd,
  input wire logic [3:0] cmd_burst_len,
  input wire logic [2:0] mr_sel,
  input wire logic [ADDR_W-1:0] mr_opcode,
  input wire pwr_t pwr_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Selected strobe pattern with clock enable high now and before, pipeline settled.
  sequence s_pins(r, c, w);
    $past(rst_n, 7) && cke && $past(cke) && !cs_n && ras_n == r && cas_n == c && we_n == w;
  endsequence
  wr_decode_a: assert property (s_pins(1, 0, 0) |-> ##3 cmd_valid && cmd == CMD_WRITE)
    else $error("write not decoded");
  rd_decode_a: assert property (s_pins(1, 0, 1) |-> ##3 cmd_valid && cmd == CMD_READ)
    else $error("read not decoded");
  mode_target_a: assert property (s_pins(0, 0, 0) |-> ##3 mr_sel == 3'($past(bank_addr, 3))
    && mr_opcode == $past(addr, 3)) else $error("mode target wrong");
  auto_pre_a: assert property (s_pins(1, 0, we_n)
    |-> ##3 cmd_auto_pre == $past(addr[AUTO_PRE_BIT], 3)) else $error("auto precharge wrong");
  desel_nop_a: assert property ($past(rst_n, 7) && cke && $past(cke) && cs_n
    |-> ##3 (!cmd_valid || cmd == CMD_DESELECT)) else $error("deselect decoded wrong");
  full_burst_a: assert property (cmd_valid && cmd inside {CMD_READ, CMD_WRITE}
    && cmd_burst_len == BURST_FULL |-> burst_busy [*4]) else $error("burst cut short");
  sr_odt_off_a: assert property (pwr_state == PWR_SELF_REFRESH |-> !odt_enable)
    else $error("termination on in self refresh");
  pd_no_ref_a: assert property (pwr_state == PWR_POWER_DOWN
    |-> !(cmd_valid && cmd == CMD_REFRESH)) else $error("refresh in power-down");
  pd_quiet_a: assert property (pwr_state == PWR_POWER_DOWN && !cke && !$past(cke)
    |-> ##3 !cmd_valid) else $error("command decoded in power-down");
  odt_pass_a: assert property (pwr_state != PWR_SELF_REFRESH
    |-> odt_enable == $past(odt, 2)) else $error("termination request not passed");
endmodule // cmd_decoder_asserts

bind cmd_decoder cmd_decoder_asserts #(.BANK_W(BANK_W), .ADDR_W(ADDR_W)) chk (.clk, .rst_n,
  .cke, .cs_n, .ras_n, .cas_n, .we_n, .odt, .bank_addr, .addr, .cmd_valid, .cmd_auto_pre,
  .burst_busy, .odt_enable, .cmd, .cmd_burst_len, .mr_sel, .mr_opcode, .pwr_state);

// ==== dv/ctrl_model.sv ====
`timescale 1ns/10ps
module ctrl_model (
  // Clock.
  input wire logic clk,
  // Command and address pins.
  output logic cke, cs_n, ras_n, cas_n, we_n,
  output logic [2:0] bank_addr,
  output logic [14:0] addr
);
  // Start idle with the no-operation pattern.
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h17;
    bank_addr = 3'h0;
    addr = 15'h0;
  end
  // One command for one cycle, then back to no-operation with clock enable kept.
  task automatic put(logic k, logic [3:0] p, logic [2:0] ba, logic [14:0] a);
    @(posedge clk) #1;
    cke = k;
    if (p[3]) begin
      // Deselected: don't-care pins flip so no stale value shows.
      {cs_n, ras_n, cas_n, we_n, bank_addr, addr} = {1'b1, ~{ras_n, cas_n, we_n, bank_addr, addr}};
    end else begin
      {cs_n, ras_n, cas_n, we_n, bank_addr, addr} = {p, ba, a};
    end
    @(posedge clk) #1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
  endtask
endmodule // ctrl_model

// ==== dv/ddr3_command_decoder_test.sv ====
`timescale 1ns/10ps
module ddr3_command_decoder_test
  import cmd_decode_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, odt = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, cmd_valid, cmd_auto_pre, burst_busy, odt_enable, wake;
  logic [2:0] bank_addr, cmd_bank, mr_sel;
  logic [14:0] addr, cmd_row, mr_opcode;
  logic [9:0] cmd_col;
  logic [3:0] cmd_burst_len;
  cmd_t cmd;
  pwr_t pwr_state;
  int fail_count = 0, checks = 0;
  always #12.5 clk = ~clk;
  ctrl_model ctl (.clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .addr);
  cmd_decoder dut (.clk, .rst_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .addr, .odt,
    .cmd_valid, .cmd, .cmd_bank, .cmd_row, .cmd_col, .cmd_auto_pre, .cmd_burst_len, .mr_sel,
    .mr_opcode, .burst_busy, .pwr_state, .odt_enable, .self_ref_wake(wake));
  task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Issue a command and return when its decode is on the outputs.
  task automatic go(logic k, logic [3:0] p, logic [2:0] ba, logic [14:0] a);
    ctl.put(k, p, ba, a);
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Column command, its fields, then busy cycles counted.
  task automatic col(logic rd, logic a12, logic a10, logic [2:0] ba, logic [3:0] len);
    int n;
    n = 0;
    go(1'b1, {3'h2, rd}, ba, {2'h0, a12, 1'b0, a10, 7'h0, ba});
    cmp("cmd", {1'b1, rd ? CMD_READ : CMD_WRITE}, {cmd_valid, cmd});
    cmp("fields", {a10, ba, 7'h0, ba, len}, {cmd_auto_pre, cmd_bank, cmd_col, cmd_burst_len});
    while (burst_busy === 1'b1 && n < 16) begin
      n++;
      @(posedge clk) #1;
    end
    cmp("busy", len >> 1, 24'(n));
  endtask
  task automatic t_table();
    logic [3:0] pat [8] = '{4'h3, 4'h1, 4'h2, 4'h2, 4'h6, 4'h6, 4'h7, 4'h8};
    logic a10 [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    cmd_t exp [8] = '{CMD_ACTIVATE, CMD_REFRESH, CMD_PRECHARGE, CMD_PRECHARGE_ALL,
      CMD_ZQ_LONG, CMD_ZQ_SHORT, CMD_NOOP, CMD_DESELECT};
    for (int i = 0; i < 8; i++) begin
      go(1'b1, pat[i], 3'h5, {4'h0, a10[i], 10'h2a5});
      cmp("cmd", {1'b1, exp[i]}, {cmd_valid, cmd});
    end
    cmp("act_row", {3'h5, 15'h02a5}, {cmd_bank, cmd_row});
  endtask
  task automatic t_burst();
    go(1'b1, 4'h0, 3'h2, 15'h1234);
    cmp("mode_target", {3'h2, 15'h1234}, {mr_sel, mr_opcode});
    go(1'b1, 4'h0, MR_BURST_IDX, {13'h0, BL_OTF});
    for (int i = 0; i < 8; i++) col(i[0], i[1], i[2], 3'(i), i[1] ? BURST_FULL : BURST_CHOP);
    go(1'b1, 4'h0, MR_BURST_IDX, {13'h0, BL_FIXED4});
    col(1'b0, 1'b1, 1'b0, 3'h1, BURST_CHOP);
    go(1'b1, 4'h0, MR_BURST_IDX, {13'h0, BL_FIXED8});
    col(1'b1, 1'b0, 1'b0, 3'h6, BURST_FULL);
  endtask
  task automatic t_power();
    int n;
    logic woke;
    woke = 1'b0;
    odt = 1'b1;
    go(1'b0, 4'h7, 3'h0, 15'h0);
    cmp("cmd", {1'b1, CMD_POWER_DOWN_ENTER}, {cmd_valid, cmd});
    go(1'b0, 4'h1, 3'h0, 15'h0);
    cmp("refused", 1'b0, cmd_valid);
    go(1'b1, 4'h7, 3'h0, 15'h0);
    cmp("cmd", {1'b1, CMD_POWER_DOWN_EXIT}, {cmd_valid, cmd});
    cmp("odt_on", 1'b1, odt_enable);
    go(1'b0, 4'h1, 3'h0, 15'h0);
    cmp("cmd", {1'b1, CMD_SELF_REF_ENTER}, {cmd_valid, cmd});
    repeat (2) @(posedge clk);
    #1;
    cmp("odt_off", {PWR_SELF_REFRESH, 1'b0}, {pwr_state, odt_enable});
    ctl.put(1'b1, 4'h7, 3'h0, 15'h0);
    for (n = 0; n < 12 && !(cmd_valid === 1'b1 && cmd === CMD_SELF_REF_EXIT); n++) begin
      woke = woke | (wake === 1'b1);
      @(posedge clk) #1;
    end
    cmp("sr_exit", 1'b1, n < 12);
    cmp("sr_wake", 1'b1, woke);
    repeat (512) @(posedge clk);
    col(1'b0, 1'b1, 1'b1, 3'h3, BURST_FULL);
  endtask
  task automatic conclude();
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    t_table();
    t_burst();
    t_power();
    conclude();
  end
  // Watchdog well past the expected run of under 2000 clocks.
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule // ddr3_command_decoder_test
